//--- core/hpsm_pkg.sv
package hpsm_pkg;

   localparam int unsigned NSLOT = 2;
   localparam int unsigned CMDW  = 4;

   // Register byte offsets
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_CMD    = 4'h4;
   localparam logic [3:0] OFS_CTRL   = 4'h8;

   // Command nibble fields, one nibble per slot
   localparam int unsigned CMD_PWR = 0;
   localparam int unsigned CMD_RST = 1;
   localparam int unsigned CMD_ATT = 2;
   localparam int unsigned CMD_VIO = 3;

   // Status fields
   localparam int unsigned ST_MODE  = 0;
   localparam int unsigned ST_FORCE = 2;
   localparam int unsigned ST_SLOT  = 8;
   localparam int unsigned ST_SLOTW = 4;
   localparam int unsigned SS_MAIN  = 0;
   localparam int unsigned SS_AUX   = 1;
   localparam int unsigned SS_OFF   = 2;
   localparam int unsigned SS_ON    = 3;

   localparam logic [7:0] CMD_RESET  = 8'h22;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef enum logic [1:0] {
      HPSM_SINGLE,
      HPSM_MULTI,
      HPSM_DIRECT
   } hpsm_mode_t;

   typedef struct packed {
      logic       supplies_valid;
      logic       mode_select_a;
      logic       mode_select_b;
      logic [1:0] ser_clk;
      logic [1:0] ser_load;
      logic [1:0] controller_in_serial;
      logic [1:0] power_indicator;
      logic [1:0] latch_sense_input;
      logic [1:0] main_power_request;
      logic [1:0] slot_reset_request_n;
      logic [1:0] attention_request;
      logic [1:0] io_voltage_choice;
      logic [1:0] capability_bit3;
      logic [1:0] main_overcurrent;
      logic [1:0] aux_overcurrent;
      logic [1:0] slot_voltage_present;
   } hpsm_pins_t;

   typedef struct packed {
      logic main_on;
      logic aux_on;
      logic main_flt;
      logic aux_flt;
      logic bus_connect;
      logic clock_connect;
      logic slot_reset_out;
      logic attention_indicator;
      logic io_voltage_sel;
      logic slot_off_status;
      logic speed66_select;
      logic speed66_oe_n;
   } hpsm_slot_t;

endpackage

//--- core/hpsm_slot_ctrl.sv
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - single-slot serial mode gives each slot its own independent serial port.
// - both mode selects low at supplies_valid rise selects single-slot serial.
// - multi-slot serial uses one cascadable serial port for both slots.
// - mode_select_a high, mode_select_b low selects multi-slot serial.
// - controller_out_serial leaves the device, controller_in_serial enters it.
// - mode_select_b high, mode_select_a low selects direct mode.
// - direct mode takes all commands from dedicated input pins.
// - a floating mode_select_a reads low through an internal pull-down.
// - main fault while main power on asserts main_problem_flag.
// - aux over-current while aux and main on asserts aux and main problem flags.
// - power_indicator low at supplies_valid rise force-enables that slot.
// - force-enabled with latch low powers aux and main; vio from capability.
// - force mode slot power controlled only by latch; status stays readable.
// - any fault in force mode powers the slot down without a command.
// - main faults clear on request deassert, aux faults on latch release.
// - force in serial: bus and clock connect, reset follows request, 66 off.
// - force in serial: attention indicator held deasserted.
// - power fault shuts power, drops bus and clock connect, asserts reset.
// - slot_off_status of a slot only when that slot's voltage is below threshold.
// - per slot drive bus_connect, clock_connect and slot_reset_out.
// - force mode ignores io_voltage_choice, uses capability_bit3.
// - modes are entered only with supplies_valid high.
module hpsm_slot_ctrl
   import hpsm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        supplies_valid_i,
   input  wire logic        mode_select_a_i,
   input  wire logic        mode_select_b_i,
   input  wire logic [1:0]  ser_clk_i,
   input  wire logic [1:0]  ser_load_i,
   input  wire logic [1:0]  controller_in_serial_i,
   output logic      [1:0]  controller_out_serial_o,
   input  wire logic [1:0]  power_indicator_i,
   input  wire logic [1:0]  latch_sense_input_i,
   input  wire logic [1:0]  main_power_request_i,
   input  wire logic [1:0]  slot_reset_request_n_i,
   input  wire logic [1:0]  attention_request_i,
   input  wire logic [1:0]  io_voltage_choice_i,
   input  wire logic [1:0]  capability_bit3_i,
   input  wire logic [1:0]  main_overcurrent_i,
   input  wire logic [1:0]  aux_overcurrent_i,
   input  wire logic [1:0]  slot_voltage_present_i,
   output logic      [1:0]  main_power_en_o,
   output logic      [1:0]  aux_power_en_o,
   output logic      [1:0]  main_problem_flag_o,
   output logic      [1:0]  aux_problem_flag_o,
   output logic      [1:0]  bus_connect_o,
   output logic      [1:0]  clock_connect_o,
   output logic      [1:0]  slot_reset_out_o,
   output logic      [1:0]  attention_indicator_o,
   output logic      [1:0]  io_voltage_sel_o,
   output logic      [1:0]  slot_off_status_o,
   output logic      [1:0]  speed66_select_o,
   output logic      [1:0]  speed66_select_oe_n_o
);

   typedef struct packed {
      hpsm_pins_t       sy1;
      hpsm_pins_t       sy2;
      hpsm_pins_t       sy3;
      hpsm_mode_t       mode;
      logic [1:0]       force_en;
      logic [7:0]       shift;
      logic [7:0]       cmd;
      logic [1:0]       ctrl;
      logic [1:0]       ser_out;
      hpsm_slot_t [1:0] slot;
      logic             ack;
      logic [31:0]      rdata;
   } hpsm_state_t;

   hpsm_state_t s_r;
   hpsm_state_t s_nxt;
   hpsm_pins_t  pins;

   function automatic hpsm_mode_t mode_decode(input logic a, input logic b);
      hpsm_mode_t m;
      m = HPSM_SINGLE;
      if (a && !b)
         m = HPSM_MULTI;
      else if (!a && b)
         m = HPSM_DIRECT;
      return m;
   endfunction

   function automatic logic [3:0] slot_status(input hpsm_slot_t sl);
      logic [3:0] v;
      v = '0;
      v[SS_MAIN] = sl.main_flt;
      v[SS_AUX]  = sl.aux_flt;
      v[SS_OFF]  = sl.slot_off_status;
      v[SS_ON]   = sl.main_on;
      return v;
   endfunction

   always_comb begin
      pins = '{
         supplies_valid:       supplies_valid_i,
         mode_select_a:        mode_select_a_i,
         mode_select_b:        mode_select_b_i,
         ser_clk:              ser_clk_i,
         ser_load:             ser_load_i,
         controller_in_serial: controller_in_serial_i,
         power_indicator:      power_indicator_i,
         latch_sense_input:    latch_sense_input_i,
         main_power_request:   main_power_request_i,
         slot_reset_request_n: slot_reset_request_n_i,
         attention_request:    attention_request_i,
         io_voltage_choice:    io_voltage_choice_i,
         capability_bit3:      capability_bit3_i,
         main_overcurrent:     main_overcurrent_i,
         aux_overcurrent:      aux_overcurrent_i,
         slot_voltage_present: slot_voltage_present_i
      };
   end

   always_comb begin
      hpsm_pins_t p;
      hpsm_pins_t q;
      logic       live;
      logic       serial;
      logic       wr;
      logic [3:0] img;
      logic       preq;
      logic       areq;
      logic       rreq;
      logic       att;
      logic       vio;
      logic       mflt;
      logic       aflt;
      logic       mon;
      p      = '0;
      q      = '0;
      live   = 1'b0;
      serial = 1'b0;
      wr     = 1'b0;
      img    = '0;
      preq   = 1'b0;
      areq   = 1'b0;
      rreq   = 1'b0;
      att    = 1'b0;
      vio    = 1'b0;
      mflt   = 1'b0;
      aflt   = 1'b0;
      mon    = 1'b0;
      s_nxt  = s_r;

      s_nxt.sy1 = pins;
      s_nxt.sy2 = s_r.sy1;
      s_nxt.sy3 = s_r.sy2;
      p = s_r.sy2;
      q = s_r.sy3;

      // Mode is latched on the supplies_valid rise only
      if (p.supplies_valid && !q.supplies_valid) begin
         s_nxt.mode     = mode_decode(p.mode_select_a,
                                      p.mode_select_b);
         s_nxt.force_en = ~p.power_indicator;
      end
      live   = p.supplies_valid && q.supplies_valid;
      serial = (s_r.mode != HPSM_DIRECT);

      // Serial ports: shift on clock rise, exchange on load rise
      unique case (s_r.mode)
         HPSM_MULTI: begin
            if (p.ser_clk[0] && !q.ser_clk[0])
               s_nxt.shift = {s_r.shift[6:0],
                              p.controller_in_serial[0]};
            if (p.ser_load[0] && !q.ser_load[0]) begin
               s_nxt.cmd   = s_r.shift;
               s_nxt.shift = {slot_status(s_r.slot[1]),
                              slot_status(s_r.slot[0])};
            end
            s_nxt.ser_out = {1'b0, s_r.shift[7]};
         end
         HPSM_SINGLE: begin
            for (int c = 0; c < NSLOT; c++) begin
               if (p.ser_clk[c] && !q.ser_clk[c])
                  s_nxt.shift[c*CMDW +: CMDW] =
                     {s_r.shift[c*CMDW +: CMDW-1],
                      p.controller_in_serial[c]};
               if (p.ser_load[c] && !q.ser_load[c]) begin
                  s_nxt.cmd[c*CMDW +: CMDW]   = s_r.shift[c*CMDW +: CMDW];
                  s_nxt.shift[c*CMDW +: CMDW] = slot_status(s_r.slot[c]);
               end
               s_nxt.ser_out[c] = s_r.shift[c*CMDW + CMDW-1];
            end
         end
         default: begin
            s_nxt.ser_out = '0;
         end
      endcase

      // Register bus, single-cycle answer
      wr = wb_cyc_i && wb_stb_i && !s_r.ack;
      s_nxt.ack = wr;
      if (wr) begin
         s_nxt.rdata = '0;
         if (wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == OFS_CMD)
               s_nxt.cmd = wb_dat_i[7:0];
            else if (wb_adr_i == OFS_CTRL)
               s_nxt.ctrl = wb_dat_i[1:0];
         end
         unique case (wb_adr_i)
            OFS_STATUS: begin
               s_nxt.rdata[ST_MODE +: 2]  = s_r.mode;
               s_nxt.rdata[ST_FORCE +: 2] = s_r.force_en;
               for (int c = 0; c < NSLOT; c++)
                  s_nxt.rdata[ST_SLOT + c*ST_SLOTW +: ST_SLOTW] =
                     slot_status(s_r.slot[c]);
            end
            OFS_CMD:  s_nxt.rdata[7:0] = s_r.cmd;
            OFS_CTRL: s_nxt.rdata[1:0] = s_r.ctrl;
            default:  s_nxt.rdata = '0;
         endcase
      end

      for (int c = 0; c < NSLOT; c++) begin
         // Command source by mode
         if (s_r.force_en[c]) begin
            preq = !p.latch_sense_input[c];
            rreq = !p.slot_reset_request_n[c];
            att  = 1'b0;
            vio  = p.capability_bit3[c];
         end else if (!serial) begin
            preq = p.main_power_request[c];
            rreq = !p.slot_reset_request_n[c];
            att  = p.attention_request[c];
            vio  = p.io_voltage_choice[c];
         end else begin
            preq = s_r.cmd[c*CMDW + CMD_PWR];
            rreq = s_r.cmd[c*CMDW + CMD_RST];
            att  = s_r.cmd[c*CMDW + CMD_ATT];
            vio  = s_r.cmd[c*CMDW + CMD_VIO];
         end
         areq = !p.latch_sense_input[c];

         // Fault flags: release first, so a new fault wins
         mflt = s_r.slot[c].main_flt && preq;
         aflt = s_r.slot[c].aux_flt && areq;
         if (s_r.slot[c].main_on && p.main_overcurrent[c])
            mflt = 1'b1;
         if (s_r.slot[c].aux_on && p.aux_overcurrent[c]) begin
            aflt = 1'b1;
            if (s_r.slot[c].main_on)
               mflt = 1'b1;
         end
         if (!live) begin
            mflt = 1'b0;
            aflt = 1'b0;
         end

         mon = live && preq && !mflt && !aflt;
         s_nxt.slot[c].main_flt       = mflt;
         s_nxt.slot[c].aux_flt        = aflt;
         s_nxt.slot[c].main_on        = mon;
         s_nxt.slot[c].aux_on         = live && areq && !aflt;
         s_nxt.slot[c].bus_connect    = mon;
         s_nxt.slot[c].clock_connect  = mon;
         s_nxt.slot[c].slot_reset_out = !mon || rreq;
         s_nxt.slot[c].attention_indicator = live && att;
         s_nxt.slot[c].io_voltage_sel      = live && vio;
         s_nxt.slot[c].slot_off_status =
            !p.slot_voltage_present[c];
         s_nxt.slot[c].speed66_select = s_r.ctrl[c];
         s_nxt.slot[c].speed66_oe_n   =
            s_r.force_en[c] && serial;
      end

      if (!p.supplies_valid) begin
         s_nxt.force_en = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r       <= '0;
         s_r.mode  <= HPSM_SINGLE;
         s_r.cmd   <= CMD_RESET;
         s_r.ctrl  <= CTRL_RESET;
         for (int c = 0; c < NSLOT; c++) begin
            s_r.slot[c].slot_reset_out  <= 1'b1;
            s_r.slot[c].slot_off_status <= 1'b1;
            s_r.slot[c].speed66_oe_n    <= 1'b1;
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o                = s_r.rdata;
   assign wb_ack_o                = s_r.ack;
   assign controller_out_serial_o = s_r.ser_out;

   for (genvar g = 0; g < NSLOT; g++) begin : g_out
      assign main_power_en_o[g]       = s_r.slot[g].main_on;
      assign aux_power_en_o[g]        = s_r.slot[g].aux_on;
      assign main_problem_flag_o[g]   = s_r.slot[g].main_flt;
      assign aux_problem_flag_o[g]    = s_r.slot[g].aux_flt;
      assign bus_connect_o[g]         = s_r.slot[g].bus_connect;
      assign clock_connect_o[g]       = s_r.slot[g].clock_connect;
      assign slot_reset_out_o[g]      = s_r.slot[g].slot_reset_out;
      assign attention_indicator_o[g] = s_r.slot[g].attention_indicator;
      assign io_voltage_sel_o[g]      = s_r.slot[g].io_voltage_sel;
      assign slot_off_status_o[g]     = s_r.slot[g].slot_off_status;
      assign speed66_select_o[g]      = s_r.slot[g].speed66_select;
      assign speed66_select_oe_n_o[g] = s_r.slot[g].speed66_oe_n;
   end

endmodule

//--- tb/hpsm_slot_ctrl_chk.sv
`timescale 1ns/1ps
module hpsm_slot_ctrl_chk
   import hpsm_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       supplies_valid_i,
   input wire logic [1:0] latch_sense_input_i,
   input wire logic [1:0] main_overcurrent_i,
   input wire logic [1:0] aux_overcurrent_i,
   input wire logic [1:0] slot_voltage_present_i,
   input wire logic [1:0] main_power_en_o,
   input wire logic [1:0] aux_power_en_o,
   input wire logic [1:0] main_problem_flag_o,
   input wire logic [1:0] aux_problem_flag_o,
   input wire logic [1:0] bus_connect_o,
   input wire logic [1:0] clock_connect_o,
   input wire logic [1:0] slot_reset_out_o,
   input wire logic [1:0] slot_off_status_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   property p_mflag;
      $rose(main_overcurrent_i[0]) && main_power_en_o[0]
         |-> ##[1:6] main_problem_flag_o[0];
   endproperty
   property p_mdown;
      $rose(main_overcurrent_i[0]) && main_power_en_o[0] |-> ##[1:6]
         (!main_power_en_o[0] && !bus_connect_o[0] && slot_reset_out_o[0]);
   endproperty
   property p_aflags;
      $rose(aux_overcurrent_i[0]) && main_power_en_o[0]
         |-> ##[1:6] (aux_problem_flag_o[0] && main_problem_flag_o[0]);
   endproperty
   property p_adown;
      $rose(aux_overcurrent_i[0]) && aux_power_en_o[0]
         |-> ##[1:6] !aux_power_en_o[0];
   endproperty
   property p_ahold;
      (supplies_valid_i && !latch_sense_input_i[0])[*5]
         ##0 aux_problem_flag_o[0] |=> aux_problem_flag_o[0];
   endproperty
   property p_offst;
      (supplies_valid_i && slot_voltage_present_i[0])[*8]
         |-> !slot_off_status_o[0];
   endproperty
   property p_busclk;
      bus_connect_o == clock_connect_o;
   endproperty

   a_ack: assert property (p_ack)
      else $error("bus ack is not a single pulse");
   a_mflag: assert property (p_mflag)
      else $error("main problem flag missing");
   a_mdown: assert property (p_mdown)
      else $error("slot not shut down on main fault");
   a_aflags: assert property (p_aflags)
      else $error("aux fault flags missing");
   a_adown: assert property (p_adown)
      else $error("aux power kept on aux fault");
   a_ahold: assert property (p_ahold)
      else $error("aux flag cleared with latch closed");
   a_offst: assert property (p_offst)
      else $error("off status with slot voltage present");
   a_busclk: assert property (p_busclk)
      else $error("bus and clock connect differ");

   c_fault: cover property ($rose(main_problem_flag_o[0]));
   c_bus: cover property ($rose(bus_connect_o[0]));
   c_off: cover property ($fell(slot_off_status_o[0]));
endmodule

bind hpsm_slot_ctrl hpsm_slot_ctrl_chk u_chk (.*);

//--- tb/hpsm_sys_model.sv
`timescale 1ns/1ps
module hpsm_sys_model
   import hpsm_pkg::*;
#(
   parameter int unsigned OFF_WAIT = 16
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] main_power_en_i,
   input  wire logic [1:0] aux_power_en_i,
   input  wire logic [1:0] main_problem_flag_i,
   input  wire logic [1:0] main_power_request_i,
   input  wire logic [1:0] backfeed_i,
   output logic      [1:0] slot_voltage_present_o,
   output logic      [1:0] main_only_problem_o,
   output logic      [1:0] off_timeout_o
);
   logic [15:0] cnt_r [NSLOT];

   // Rails sit at zero unless switched on or fed from elsewhere
   assign slot_voltage_present_o = main_power_en_i | aux_power_en_i
                                 | backfeed_i;
   assign main_only_problem_o = main_power_en_i | main_problem_flag_i;

   always_ff @(posedge clk_i) begin
      for (int s = 0; s < NSLOT; s++) begin
         if (rst_i || main_power_request_i[s])
            cnt_r[s] <= 16'h0;
         else if (cnt_r[s] < OFF_WAIT[15:0])
            cnt_r[s] <= cnt_r[s] + 16'h1;
         off_timeout_o[s] <= (cnt_r[s] == OFF_WAIT[15:0]);
      end
   end
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) chk(n, e, a)
module tb
   import hpsm_pkg::*;
;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        supplies_valid_i, mode_select_a_i, mode_select_b_i;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [1:0]  ser_clk_i, ser_load_i, controller_in_serial_i;
   logic [1:0]  power_indicator_i, latch_sense_input_i, backfeed;
   logic [1:0]  main_power_request_i, slot_reset_request_n_i;
   logic [1:0]  attention_request_i, io_voltage_choice_i, capability_bit3_i;
   logic [1:0]  main_overcurrent_i, aux_overcurrent_i, slot_voltage_present_i;
   logic [1:0]  controller_out_serial_o, main_power_en_o, aux_power_en_o;
   logic [1:0]  main_problem_flag_o, aux_problem_flag_o, bus_connect_o;
   logic [1:0]  clock_connect_o, slot_reset_out_o, attention_indicator_o;
   logic [1:0]  io_voltage_sel_o, slot_off_status_o, speed66_select_o;
   logic [1:0]  speed66_select_oe_n_o;
   int          bad_count, num_checks;

   hpsm_slot_ctrl u_dut (.*);

   hpsm_sys_model u_sys (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .main_power_en_i        (main_power_en_o),
      .aux_power_en_i         (aux_power_en_o),
      .main_problem_flag_i    (main_problem_flag_o),
      .main_power_request_i   (main_power_request_i),
      .backfeed_i             (backfeed),
      .slot_voltage_present_o (slot_voltage_present_i),
      .main_only_problem_o    (),
      .off_timeout_o          ()
   );

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] a);
      num_checks++;
      if (a !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, a);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic bus(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      `CHK("ack", 1'h1, wb_ack_o);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask

   task automatic pu(input logic a, input logic b, input logic [1:0] pi);
      w(1);
      supplies_valid_i <= 1'h0;
      mode_select_a_i  <= a;
      mode_select_b_i  <= b;
      power_indicator_i <= pi;
      w(6);
      supplies_valid_i <= 1'h1;
      w(8);
   endtask

   // Shift n bits of v, MSB first, on the channels in m, then load if ld
   task automatic ser(input logic [1:0] m, input int n,
                      input logic [7:0] v, input logic ld);
      for (int k = n - 1; k >= 0; k--) begin
         controller_in_serial_i <= m & {2{v[k]}};
         w(4);
         ser_clk_i <= m;
         w(4);
         ser_clk_i <= 2'h0;
      end
      if (ld) begin
         w(4);
         ser_load_i <= m;
         w(4);
         ser_load_i <= 2'h0;
      end
      w(6);
   endtask

   initial begin
      clk_i = 1'h0;
      forever #2.5 clk_i = ~clk_i;
   end

   initial begin
      w(5000);
      bad_count++;
      $display("watchdog expired");
      close_out;
   end

   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, supplies_valid_i} = 5'h10;
      {mode_select_a_i, mode_select_b_i, wb_adr_i} = 6'h0;
      {wb_sel_i, wb_dat_i} = {4'hf, 32'h0};
      {ser_clk_i, ser_load_i, controller_in_serial_i} = 6'h0;
      {power_indicator_i, latch_sense_input_i} = 4'hf;
      {backfeed, main_power_request_i, attention_request_i} = 6'h0;
      slot_reset_request_n_i = 2'h3;
      {io_voltage_choice_i, capability_bit3_i} = 4'h1;
      {main_overcurrent_i, aux_overcurrent_i} = 4'h0;
      w(11);
      `CHK("reset out", 6'h3f, {slot_reset_out_o, slot_off_status_o,
           speed66_select_oe_n_o});
      w(1);
      rst_i <= 1'h0;
      bus(1'h0, OFS_CMD, 32'h0);
      `CHK("cmd", {24'h0, CMD_RESET}, rd);
      bus(1'h1, OFS_CMD, 32'h5a);
      bus(1'h0, OFS_CMD, 32'h0);
      `CHK("cmd wr", 32'h5a, rd);
      bus(1'h1, OFS_CMD, {24'h0, CMD_RESET});
      bus(1'h0, 4'hc, 32'h0);
      `CHK("unmapped", 32'h0, rd);
      bus(1'h1, OFS_CTRL, 32'h2);
      bus(1'h0, OFS_CTRL, 32'h0);
      `CHK("ctrl", 32'h2, rd);
      `CHK("speed66", 2'h2, speed66_select_o);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         pu(i[0], i[1], 2'h3);
         bus(1'h0, OFS_STATUS, 32'h0);
         `CHK("mode", (i == 3) ? 2'h0 : i[1:0], rd[1:0]);
         mode_select_a_i <= ~mode_select_a_i;
         mode_select_b_i <= ~mode_select_b_i;
         w(8);
         bus(1'h0, OFS_STATUS, 32'h0);
         `CHK("mode kept", (i == 3) ? 2'h0 : i[1:0], rd[1:0]);
      end
      $display("test modes done");
      pu(1'h0, 1'h1, 2'h3);
      main_power_request_i <= 2'h1;
      attention_request_i  <= 2'h2;
      w(8);
      `CHK("direct", 6'h18, {main_power_en_o, attention_indicator_o,
           controller_out_serial_o});
      main_power_request_i <= 2'h0;
      attention_request_i  <= 2'h0;
      $display("test direct done");
      pu(1'h0, 1'h0, 2'h2);
      bus(1'h0, OFS_STATUS, 32'h0);
      `CHK("force st", 2'h1, rd[3:2]);
      latch_sense_input_i <= 2'h2;
      w(8);
      `CHK("force pwr", 3'h7, {main_power_en_o[0], aux_power_en_o[0],
           io_voltage_sel_o[0]});
      `CHK("force bus", 5'h19, {bus_connect_o[0], clock_connect_o[0],
           attention_indicator_o[0], slot_reset_out_o[0],
           speed66_select_oe_n_o[0]});
      `CHK("slot b", 1'h0, main_power_en_o[1]);
      slot_reset_request_n_i <= 2'h2;
      w(8);
      `CHK("rst follow", 1'h1, slot_reset_out_o[0]);
      slot_reset_request_n_i <= 2'h3;
      main_overcurrent_i <= 2'h1;
      w(8);
      `CHK("main fault", 5'h03, {main_power_en_o[0], bus_connect_o[0],
           clock_connect_o[0], slot_reset_out_o[0],
           main_problem_flag_o[0]});
      main_overcurrent_i <= 2'h0;
      w(8);
      `CHK("flag held", 1'h1, main_problem_flag_o[0]);
      latch_sense_input_i <= 2'h3;
      w(8);
      `CHK("flag clr", 1'h0, main_problem_flag_o[0]);
      w(8);
      `CHK("off", 1'h1, slot_off_status_o[0]);
      backfeed <= 2'h1;
      w(8);
      `CHK("backfed", 1'h0, slot_off_status_o[0]);
      backfeed <= 2'h0;
      latch_sense_input_i <= 2'h2;
      w(8);
      aux_overcurrent_i <= 2'h1;
      w(8);
      `CHK("aux fault", 3'h6, {aux_problem_flag_o[0],
           main_problem_flag_o[0], aux_power_en_o[0]});
      aux_overcurrent_i <= 2'h0;
      latch_sense_input_i <= 2'h3;
      w(8);
      `CHK("aux clr", 1'h0, aux_problem_flag_o[0]);
      $display("test force done");
      pu(1'h0, 1'h0, 2'h3);
      ser(2'h2, 4, 8'h05, 1'h1);
      `CHK("ser slot", 6'h29, {main_power_en_o, attention_indicator_o,
           slot_reset_out_o});
      bus(1'h0, OFS_CMD, 32'h0);
      `CHK("ser cmd", 32'h52, rd);
      ser(2'h2, 1, 8'h00, 1'h0);
      `CHK("ser out", 2'h2, controller_out_serial_o);
      pu(1'h1, 1'h0, 2'h3);
      ser(2'h1, 8, 8'h96, 1'h0);
      `CHK("cascade", 2'h1, controller_out_serial_o);
      ser(2'h1, 0, 8'h00, 1'h1);
      bus(1'h0, OFS_CMD, 32'h0);
      `CHK("multi cmd", 32'h96, rd);
      `CHK("multi slot", 6'h26, {main_power_en_o, attention_indicator_o,
           io_voltage_sel_o});
      $display("test serial done");
      close_out;
   end
endmodule
